// File: pkg/rtcb_pkg.sv
// Summary of operation
// - 32768 Hz base drives millisecond-to-month counting
// - 24-hour clock, one-year calendar, no leap
// - BCD digits, two per bus cycle
// - unused digit bits read zero, writes ignored
// - tens-of-hours keeps only two low bits
// - 56-bit RAM, 14 fully writable digits
// - compare skips ten-thousandths and weekday digits
// - RAM digit with top bits 11 always matches
// - unused counter bits match only RAM zeros
// - compare valid 61 us after millisecond tick
// - enabled rollover or compare clocks status register
// - interrupt output high within 5 us
// - status read end drops interrupt within 5 us
// - enabled standby interrupt low within 5 us
// - writing zero at 16H releases standby interrupt
// - read: ready low fast, data within 800 ns
// - write: ready low at most 800 ns
// - power-down isolates bus, timekeeping and standby continue
// - eight interrupt sources, one enable bit each
// - status read returns causes, read end clears
// - standby enabled or disabled by bit 0 at 16H
// - standby set by compare level, not edge, held until released
package rtcb_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned OSC_HZ = 32768;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned RDY_LOW_NS = 200;
    localparam int unsigned RDY_LOW_CYC = RDY_LOW_NS / CLK_PERIOD_NS;
    localparam int unsigned CMP_DLY_NS = 61000;
    localparam int unsigned CMP_DLY_CYC = (CMP_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // address map
    // ---------------------------------------------------------------
    localparam logic [4:0] ADR_ISR = 5'h10;
    localparam logic [4:0] ADR_ICR = 5'h11;
    localparam logic [4:0] ADR_CRST = 5'h12;
    localparam logic [4:0] ADR_LRST = 5'h13;
    localparam logic [4:0] ADR_STAT = 5'h14;
    localparam logic [4:0] ADR_GO = 5'h15;
    localparam logic [4:0] ADR_STBY = 5'h16;
    localparam logic [1:0] PAGE_CNT = 2'h0;
    localparam logic [1:0] PAGE_RAM = 2'h1;

    // ---------------------------------------------------------------
    // interrupt bit positions
    // ---------------------------------------------------------------
    localparam int IRQ_CMP = 0;
    localparam int IRQ_10HZ = 1;
    localparam int IRQ_1HZ = 2;
    localparam int IRQ_MIN = 3;
    localparam int IRQ_HOUR = 4;
    localparam int IRQ_DAY = 5;
    localparam int IRQ_WEEK = 6;
    localparam int IRQ_MON = 7;

    // ---------------------------------------------------------------
    // counter fields, one per address 0..7
    // ---------------------------------------------------------------
    localparam int NUM_FLD = 8;
    localparam int F_MS = 0;
    localparam int F_CS = 1;
    localparam int F_SEC = 2;
    localparam int F_MIN = 3;
    localparam int F_HR = 4;
    localparam int F_DOW = 5;
    localparam int F_DOM = 6;
    localparam int F_MON = 7;
    localparam logic [7:0] FLD_MIN [NUM_FLD] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01};
    localparam logic [7:0] FLD_MAX [NUM_FLD] = '{8'h09, 8'h99, 8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12};
    localparam logic [7:0] FLD_MASK [NUM_FLD] = '{8'h0F, 8'hFF, 8'h7F, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F};
    localparam logic [7:0] GO_MIN_THRESH = 8'h39;
    localparam logic [7:0] DOM_FEB = 8'h28;
    localparam logic [7:0] DOM_SHORT = 8'h30;
    localparam logic [7:0] MON_FEB = 8'h02;
    localparam logic [7:0] MON_APR = 8'h04;
    localparam logic [7:0] MON_JUN = 8'h06;
    localparam logic [7:0] MON_SEP = 8'h09;
    localparam logic [7:0] MON_NOV = 8'h11;

    // ---------------------------------------------------------------
    // digit maps (nibble i = byte i/2, low nibble first)
    // ---------------------------------------------------------------
    localparam logic [15:0] RAM_STORED = 16'hF7FE;
    localparam logic [15:0] CMP_DIGITS = 16'hF3FE;
    localparam logic [1:0] DONT_CARE = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_DONE = 3'b100
    } rtcb_state_e;

    typedef struct packed {
        logic cs;
        logic rd;
        logic wr;
        logic pwr;
    } rtcb_pins_s;

endpackage : rtcb_pkg

// File: verilog/rtcb_field.sv
`timescale 1ns/10ps
module rtcb_field
    import rtcb_pkg::*;
#(
    parameter logic [7:0] MIN_VAL = 8'h00,
    parameter logic [7:0] MASK = 8'hFF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inc,
    input wire logic clr,
    input wire logic ld,
    input wire logic [7:0] ld_val,
    input wire logic [7:0] max_val,
    output logic [7:0] val,
    output logic carry
);

    // carry is suppressed when software overrides the field this cycle
    assign carry = inc && !clr && !ld && (val == max_val);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            val <= MIN_VAL;
        end else if (clr) begin
            val <= MIN_VAL;
        end else if (ld) begin
            val <= ld_val & MASK;
        end else if (inc) begin
            if (val == max_val) begin
                val <= MIN_VAL;
            end else if (val[3:0] == 4'h9) begin
                val <= {4'(val[7:4] + 4'h1), 4'h0};
            end else begin
                val <= {val[7:4], 4'(val[3:0] + 4'h1)};
            end
        end
    end

endmodule : rtcb_field

// File: verilog/rtcb_top.sv
`timescale 1ns/10ps
module rtcb_top
    import rtcb_pkg::*;
#(
    parameter int unsigned CLK_FREQ_HZ = CLK_HZ,
    parameter int unsigned OSC_FREQ_HZ = OSC_HZ,
    parameter int unsigned CMP_DELAY_CYC = CMP_DLY_CYC
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic PWRDN_N,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [4:0] ADDR,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE_N,
    output logic READY_OUT,
    output logic READY_OE_N,
    output logic INT_OUT,
    output logic INT_OE_N,
    output logic STBY_OUT,
    output logic STBY_OE_N
);

    // ---------------------------------------------------------------
    // time base
    // ---------------------------------------------------------------
    logic [31:0] osc_acc;
    logic osc_tick;
    logic [31:0] ms_acc;
    logic ms_tick;

    // fractional dividers keep the long-run rate exact
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            osc_acc <= 32'h0000_0000;
            osc_tick <= 1'b0;
        end else if (osc_acc + OSC_FREQ_HZ >= CLK_FREQ_HZ) begin
            osc_acc <= 32'(osc_acc + OSC_FREQ_HZ - CLK_FREQ_HZ);
            osc_tick <= 1'b1;
        end else begin
            osc_acc <= 32'(osc_acc + OSC_FREQ_HZ);
            osc_tick <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ms_acc <= 32'h0000_0000;
            ms_tick <= 1'b0;
        end else if (!osc_tick) begin
            ms_tick <= 1'b0;
        end else if (ms_acc + MS_PER_S >= OSC_FREQ_HZ) begin
            ms_acc <= 32'(ms_acc + MS_PER_S - OSC_FREQ_HZ);
            ms_tick <= 1'b1;
        end else begin
            ms_acc <= 32'(ms_acc + MS_PER_S);
            ms_tick <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // strobe synchroniser
    // ---------------------------------------------------------------
    rtcb_pins_s pin_raw;
    rtcb_pins_s pin_m;
    rtcb_pins_s pin_s;
    logic pd_ok;
    logic act_rd;
    logic act_wr;

    assign pin_raw = '{cs: ~CS_N, rd: ~RD_N, wr: ~WR_N, pwr: PWRDN_N};

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_m <= '0;
            pin_s <= '0;
        end else begin
            pin_m <= pin_raw;
            pin_s <= pin_m;
        end
    end

    assign pd_ok = pin_s.pwr;
    assign act_rd = pd_ok && pin_s.cs && pin_s.rd;
    assign act_wr = pd_ok && pin_s.cs && pin_s.wr;

    // ---------------------------------------------------------------
    // bus cycle sequencer
    // ---------------------------------------------------------------
    rtcb_state_e state;
    logic [7:0] wait_cnt;
    logic is_wr;
    logic [4:0] adr;
    logic do_rd;
    logic do_wr;
    logic rd_end;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= ST_IDLE;
            wait_cnt <= 8'h00;
            is_wr <= 1'b0;
            adr <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (act_rd || act_wr) begin
                        state <= ST_BUSY;
                        wait_cnt <= 8'(RDY_LOW_CYC - 1);
                        is_wr <= act_wr;
                        adr <= ADDR;
                    end
                end
                ST_BUSY: begin
                    if (!pd_ok) begin
                        state <= ST_IDLE;
                    end else if (wait_cnt == 8'h00) begin
                        state <= ST_DONE;
                    end else begin
                        wait_cnt <= 8'(wait_cnt - 8'h01);
                    end
                end
                ST_DONE: begin
                    if (!(act_rd || act_wr)) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // write data sampled at the end of the ready-low window
    assign do_rd = (state == ST_BUSY) && pd_ok && (wait_cnt == 8'h00) && !is_wr;
    assign do_wr = (state == ST_BUSY) && pd_ok && (wait_cnt == 8'h00) && is_wr;
    assign rd_end = (state == ST_DONE) && !is_wr && !act_rd && !act_wr;

    assign READY_OUT = 1'b0;
    assign READY_OE_N = !(state == ST_BUSY);
    assign DATA_OE_N = !((state == ST_DONE) && !is_wr && act_rd);

    // ---------------------------------------------------------------
    // time counter
    // ---------------------------------------------------------------
    logic [7:0] fld_val [NUM_FLD];
    logic [7:0] fld_max [NUM_FLD];
    logic [7:0] fld_din [NUM_FLD];
    logic [7:0] cnt_byte [NUM_FLD];
    logic [NUM_FLD-1:0] fld_inc;
    logic [NUM_FLD-1:0] fld_carry;
    logic [NUM_FLD-1:0] fld_ld;
    logic [NUM_FLD-1:0] fld_clr;
    logic go_cmd;
    logic go_min;
    logic ten_hz;

    assign go_cmd = do_wr && (adr == ADR_GO);
    assign go_min = go_cmd && (fld_val[F_SEC] > GO_MIN_THRESH);
    assign ten_hz = fld_inc[F_CS] && (fld_val[F_CS][3:0] == 4'h9);

    always_comb begin
        fld_inc[F_MS] = ms_tick;
        fld_inc[F_CS] = fld_carry[F_MS];
        fld_inc[F_SEC] = fld_carry[F_CS];
        fld_inc[F_MIN] = fld_carry[F_SEC] || go_min;
        fld_inc[F_HR] = fld_carry[F_MIN];
        fld_inc[F_DOW] = fld_carry[F_HR];
        fld_inc[F_DOM] = fld_carry[F_HR];
        fld_inc[F_MON] = fld_carry[F_DOM];
    end

    // february is always 28 days: no leap correction
    always_comb begin
        for (int i = 0; i < NUM_FLD; i++) begin
            fld_max[i] = FLD_MAX[i];
        end
        if (fld_val[F_MON] == MON_FEB) begin
            fld_max[F_DOM] = DOM_FEB;
        end else if (fld_val[F_MON] == MON_APR || fld_val[F_MON] == MON_JUN ||
                     fld_val[F_MON] == MON_SEP || fld_val[F_MON] == MON_NOV) begin
            fld_max[F_DOM] = DOM_SHORT;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_FLD; g++) begin : gen_fld
            // thousandths sit in the high nibble of address 0
            assign fld_din[g] = (g == F_MS) ? {4'h0, DATA_IN[7:4]} : DATA_IN;
            assign cnt_byte[g] = (g == F_MS) ? {fld_val[g][3:0], 4'h0} : fld_val[g];
            assign fld_ld[g] = do_wr && (adr == {PAGE_CNT, 3'(g)});
            assign fld_clr[g] = (do_wr && (adr == ADR_CRST) && DATA_IN[g]) || (go_cmd && (g <= F_SEC));
            rtcb_field #(
                .MIN_VAL(FLD_MIN[g]),
                .MASK(FLD_MASK[g])
            ) u_fld (
                .clk(MCLK),
                .rst_n(ARST_N),
                .inc(fld_inc[g]),
                .clr(fld_clr[g]),
                .ld(fld_ld[g]),
                .ld_val(fld_din[g]),
                .max_val(fld_max[g]),
                .val(fld_val[g]),
                .carry(fld_carry[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // RAM and comparator
    // ---------------------------------------------------------------
    logic [3:0] ram [16];
    logic match;
    logic [31:0] cmp_cnt;
    logic cmp_fire;
    logic cmp_latch;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < 16; i++) begin
                ram[i] <= 4'h0;
            end
        end else if (do_wr && (adr[4:3] == PAGE_RAM)) begin
            ram[{adr[2:0], 1'b0}] <= DATA_IN[3:0] & {4{RAM_STORED[{adr[2:0], 1'b0}]}};
            ram[{adr[2:0], 1'b1}] <= DATA_IN[7:4] & {4{RAM_STORED[{adr[2:0], 1'b1}]}};
        end else if (do_wr && (adr == ADR_LRST)) begin
            for (int i = 0; i < 8; i++) begin
                if (DATA_IN[i]) begin
                    ram[2 * i] <= 4'h0;
                    ram[2 * i + 1] <= 4'h0;
                end
            end
        end
    end

    // unused counter bits are stored as zero, so they only equal RAM zeros
    always_comb begin
        match = 1'b1;
        for (int i = 0; i < 16; i++) begin
            if (CMP_DIGITS[i] && (ram[i][3:2] != DONT_CARE) &&
                (ram[i] != cnt_byte[i / 2][(i % 2) * 4 +: 4])) begin
                match = 1'b0;
            end
        end
    end

    // the wait lets a fresh count settle before the result is trusted
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cmp_cnt <= 32'h0000_0000;
        end else if (ms_tick) begin
            cmp_cnt <= CMP_DELAY_CYC;
        end else if (cmp_cnt != 32'h0000_0000) begin
            cmp_cnt <= 32'(cmp_cnt - 32'h0000_0001);
        end
    end

    assign cmp_fire = (cmp_cnt == 32'h0000_0001);

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cmp_latch <= 1'b0;
        end else if (cmp_fire) begin
            cmp_latch <= match;
        end
    end

    // ---------------------------------------------------------------
    // interrupt control and status
    // ---------------------------------------------------------------
    logic [7:0] icr;
    logic [7:0] isr;
    logic [7:0] isr_src;
    logic [7:0] rd_snap;
    logic int_q;

    assign isr_src = {fld_carry[F_DOM], fld_carry[F_DOW], fld_carry[F_HR], fld_carry[F_MIN],
                      fld_carry[F_SEC], fld_carry[F_CS], ten_hz, cmp_fire && match};

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            icr <= 8'h00;
        end else if (do_wr && (adr == ADR_ICR)) begin
            icr <= DATA_IN;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_snap <= 8'h00;
        end else if (do_rd) begin
            rd_snap <= (adr == ADR_ISR) ? isr : 8'h00;
        end
    end

    // only bits shown to software are cleared; a new event wins
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            isr <= 8'h00;
        end else begin
            isr <= (isr & ~(rd_end ? rd_snap : 8'h00)) | (icr & isr_src);
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            int_q <= 1'b0;
        end else begin
            int_q <= |isr;
        end
    end

    assign INT_OUT = int_q;
    assign INT_OE_N = !pd_ok;

    // ---------------------------------------------------------------
    // rollover status bit
    // ---------------------------------------------------------------
    logic cnt_rd_seen;
    logic stat_bit;
    logic stat_clr;

    assign stat_clr = rd_end && (adr == ADR_STAT);

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_rd_seen <= 1'b0;
        end else if (do_rd && (adr[4:3] == PAGE_CNT)) begin
            cnt_rd_seen <= 1'b1;
        end else if (stat_clr) begin
            cnt_rd_seen <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_bit <= 1'b0;
        end else if (ms_tick && (cnt_rd_seen || ((state != ST_IDLE) && !is_wr && (adr[4:3] == PAGE_CNT)))) begin
            stat_bit <= 1'b1;
        end else if (stat_clr) begin
            stat_bit <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // standby interrupt
    // ---------------------------------------------------------------
    logic stby_en;
    logic stby_act;

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stby_en <= 1'b0;
        end else if (do_wr && (adr == ADR_STBY)) begin
            stby_en <= DATA_IN[0];
        end
    end

    // disable beats a standing match so software can always release
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stby_act <= 1'b0;
        end else if (do_wr && (adr == ADR_STBY) && !DATA_IN[0]) begin
            stby_act <= 1'b0;
        end else if (stby_en && cmp_latch) begin
            stby_act <= 1'b1;
        end
    end

    assign STBY_OUT = 1'b0;
    assign STBY_OE_N = !stby_act;

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        if (adr[4:3] == PAGE_CNT) begin
            rd_mux = cnt_byte[adr[2:0]];
        end else if (adr[4:3] == PAGE_RAM) begin
            rd_mux = {ram[{adr[2:0], 1'b1}], ram[{adr[2:0], 1'b0}]};
        end else begin
            case (adr)
                ADR_ISR: rd_mux = isr;
                ADR_ICR: rd_mux = icr;
                ADR_STAT: rd_mux = {7'h00, stat_bit};
                ADR_STBY: rd_mux = {7'h00, stby_en};
                default: rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DATA_OUT <= 8'h00;
        end else if (do_rd) begin
            DATA_OUT <= rd_mux;
        end
    end

endmodule : rtcb_top

// File: tb/rtcb_assertions.sv
`timescale 1ns/10ps
module rtcb_assertions
    import rtcb_pkg::*;
(
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic PWRDN_N,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [4:0] ADDR,
    input wire logic [7:0] DATA_IN,
    input wire logic DATA_OE_N,
    input wire logic READY_OE_N,
    input wire logic INT_OUT,
    input wire logic INT_OE_N,
    input wire logic STBY_OE_N
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);
    // ----------------------------------------
    // ready window length, read data, power-down, interrupt and standby checks
    // ----------------------------------------
    logic [7:0] rdy_low;
    always_ff @(posedge MCLK or negedge ARST_N)
        if (!ARST_N) rdy_low <= 8'h00;
        else rdy_low <= READY_OE_N ? 8'h00 : rdy_low + 8'h01;
    property p_rdy_len; $rose(READY_OE_N) |-> rdy_low == 8'h14; endproperty
    a_rdy_len: assert property (p_rdy_len) else $error("ready window length wrong");
    property p_rdy_start; $fell(RD_N) && !CS_N && PWRDN_N && READY_OE_N |-> ##[1:15] !READY_OE_N; endproperty
    a_rdy_start: assert property (p_rdy_start) else $error("ready not pulled low in time");
    property p_rd_data; $rose(READY_OE_N) && !RD_N && !CS_N |-> !DATA_OE_N; endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data not driven at ready");
    property p_rd_hz; $rose(RD_N) |-> ##[1:25] DATA_OE_N; endproperty
    a_rd_hz: assert property (p_rd_hz) else $error("data bus not released after read");
    property p_pd_off; !PWRDN_N [*4] |-> INT_OE_N && DATA_OE_N && READY_OE_N; endproperty
    a_pd_off: assert property (p_pd_off) else $error("output enabled in power-down");
    property p_pd_on; PWRDN_N [*4] |-> !INT_OE_N; endproperty
    a_pd_on: assert property (p_pd_on) else $error("interrupt pin not driven");
    property p_int_clr; !DATA_OE_N && ADDR == ADR_ISR ##1 $rose(RD_N) |-> ##[1:8] !INT_OUT; endproperty
    a_int_clr: assert property (p_int_clr) else $error("interrupt not cleared by status read");
    property p_stby_off; $rose(READY_OE_N) && !WR_N && ADDR == ADR_STBY && !DATA_IN[0] |-> STBY_OE_N; endproperty
    a_stby_off: assert property (p_stby_off) else $error("standby not released");
endmodule : rtcb_assertions

bind rtcb_top rtcb_assertions chk (.MCLK, .ARST_N, .PWRDN_N, .CS_N, .RD_N, .WR_N, .ADDR, .DATA_IN,
    .DATA_OE_N, .READY_OE_N, .INT_OUT, .INT_OE_N, .STBY_OE_N);

// File: tb/rtcb_host.sv
`timescale 1ns/10ps
module rtcb_host
    import rtcb_pkg::*;
(
    input wire logic mclk,
    input wire logic ready,
    input wire logic [7:0] data_bus,
    output logic pwrdn_n,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [4:0] addr,
    output logic [7:0] data_in
);
    int hangs = 0;
    // power-down held low until strobes and data sit at idle levels
    initial begin
        {pwrdn_n, cs_n, rd_n, wr_n} = 4'b0111;
        addr = 5'h00;
        data_in = 8'h00;
    end
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(negedge mclk);
        addr = a;
        if (wr) data_in = d;
        repeat (10) @(negedge mclk);
        {cs_n, rd_n, wr_n} = {1'b0, wr, !wr};
        while (ready && n < 40) begin
            @(posedge mclk);
            n++;
        end
        // strobes, address and data held until ready is seen released
        while (!ready && n < 80) begin
            @(posedge mclk);
            n++;
        end
        q = data_bus;
        if (n >= 40) hangs++;
        @(negedge mclk);
        {cs_n, rd_n, wr_n} = 3'b111;
        repeat (5) @(negedge mclk);
        // released bus must not keep showing the last value
        data_in = ~data_in;
    endtask : access
    task automatic set_pd(input logic v);
        @(negedge mclk);
        pwrdn_n = v;
    endtask : set_pd
    task automatic raw_wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        data_in = d;
        {cs_n, wr_n} = 2'b00;
        repeat (40) @(negedge mclk);
        {cs_n, wr_n} = 2'b11;
    endtask : raw_wr
endmodule : rtcb_host

// File: tb/rtcb_top_bench.sv
`timescale 1ns/10ps
module rtcb_top_bench
    import rtcb_pkg::*;
;
    logic MCLK, ARST_N, PWRDN_N, CS_N, RD_N, WR_N, DATA_OE_N, READY_OUT, READY_OE_N;
    logic INT_OUT, INT_OE_N, STBY_OUT, STBY_OE_N;
    logic [4:0] ADDR;
    logic [7:0] DATA_IN, DATA_OUT, q;
    logic [31:0] seed = 32'h0000_0024;
    int miscompares = 0;
    int total_checks = 0;
    // open-drain ready with pull-up
    wire ready_line = READY_OE_N | READY_OUT;
    wire stby_line = STBY_OE_N | STBY_OUT;
    // fast tick: ms every ~65 cycles, short compare delay
    rtcb_top #(.CLK_FREQ_HZ(65536), .CMP_DELAY_CYC(5)) uut (
        .MCLK, .ARST_N, .PWRDN_N, .CS_N, .RD_N, .WR_N, .ADDR, .DATA_IN, .DATA_OUT, .DATA_OE_N,
        .READY_OUT, .READY_OE_N, .INT_OUT, .INT_OE_N, .STBY_OUT, .STBY_OE_N);
    // undriven data bus shows garbage, so a late output enable is caught
    rtcb_host host (.mclk(MCLK), .ready(ready_line), .data_bus(DATA_OE_N ? ~DATA_OUT : DATA_OUT), .pwrdn_n(PWRDN_N),
        .cs_n(CS_N), .rd_n(RD_N), .wr_n(WR_N), .addr(ADDR), .data_in(DATA_IN));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [7:0] ram_exp(input int i, input logic [7:0] d);
        return d & {{4{RAM_STORED[2*i+1]}}, {4{RAM_STORED[2*i]}}};
    endfunction : ram_exp
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input string name, input logic [4:0] a, input logic [7:0] exp);
        host.access(1'b0, a, 8'h00, q);
        check(name, q, exp);
    endtask : rdc
    task automatic idle(input int n);
        repeat (n) @(negedge MCLK);
    endtask : idle
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    initial begin
        repeat (20000) @(posedge MCLK);
        miscompares++;
        report_and_stop();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        ARST_N = 1'b0;
        repeat (3) @(posedge MCLK);
        @(negedge MCLK);
        ARST_N = 1'b1;
        host.set_pd(1'b1);
        idle(4);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            wr(5'(8 + i), seed[7:0]);
            rdc("ram", 5'(8 + i), ram_exp(i, seed[7:0]));
        end
        wr(5'h04, 8'hD2);
        rdc("hours", 5'h04, 8'h12);
        wr(5'h07, 8'hE1);
        rdc("month", 5'h07, 8'h01);
        // ms cleared first so no carry lands while the rest is staged
        wr(ADR_ICR, 8'h3C);
        wr(5'h00, 8'h00);
        wr(5'h01, 8'h99);
        wr(5'h02, 8'h59);
        wr(5'h03, 8'h59);
        wr(5'h04, 8'h23);
        wr(5'h00, 8'h90);
        idle(100);
        check("int", {7'h00, INT_OUT}, 8'h01);
        rdc("status", ADR_ISR, 8'h3C);
        idle(6);
        check("int", {7'h00, INT_OUT}, 8'h00);
        rdc("sec", 5'h02, 8'h00);
        rdc("min", 5'h03, 8'h00);
        rdc("hour", 5'h04, 8'h00);
        rdc("dow", 5'h05, 8'h02);
        rdc("dom", 5'h06, 8'h02);
        for (int i = 8; i < 16; i++) wr(5'(i), 8'hFF);
        wr(ADR_STBY, 8'h01);
        idle(150);
        check("stby", {7'h00, stby_line}, 8'h00);
        wr(ADR_STBY, 8'h00);
        check("stby", {7'h00, stby_line}, 8'h01);
        host.set_pd(1'b0);
        host.raw_wr(ADR_STBY, 8'h01);
        idle(150);
        check("stby", {7'h00, stby_line}, 8'h01);
        host.set_pd(1'b1);
        idle(5);
        wr(5'h0D, 8'h05);
        wr(ADR_STBY, 8'h01);
        idle(150);
        check("stby", {7'h00, stby_line}, 8'h00);
        wr(ADR_STBY, 8'h00);
        wr(5'h0B, 8'h80);
        wr(ADR_STBY, 8'h01);
        idle(150);
        check("stby", {7'h00, stby_line}, 8'h01);
        check("hang", 8'(host.hangs), 8'h00);
        report_and_stop();
    end
endmodule : rtcb_top_bench
